// File: rtl/fbst_pkg.sv
// Package of constants and types for the FIFO boundary-scan test port
package fbst_pkg;

  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } fbst_state_t;

  // Instruction codes
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_IDCODE = 4'h2;
  localparam logic [3:0] INS_CLAMP = 4'h3;
  localparam logic [3:0] INS_HIGHZ = 4'h4;
  localparam logic [3:0] INS_THR_READ = 4'h7;
  localparam logic [3:0] INS_THR_LOAD = 4'h8;
  localparam logic [3:0] INS_BYPASS = 4'hf;

  // Instruction register layout and capture pattern
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = INS_IDCODE;

  // Identification register fields
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic [3:0] ID_VERSION = 4'h0;   // Arbitrary value
  localparam logic [15:0] ID_PART = 16'h0abc; // Arbitrary value
  localparam logic [10:0] ID_MAKER = 11'h055; // Arbitrary value

  // Threshold registers
  localparam int THR_W = 16;
  localparam logic [15:0] THR_EMPTY_RST = 16'h007f;
  localparam logic [15:0] THR_FULL_RST = 16'h007f;

  // Consecutive TMS-high edges that reach Test-Logic-Reset
  localparam int TMS_RESET_EDGES = 5;

endpackage

// File: rtl/fbst_tap.sv
// Test access port with instruction, bypass, identification and threshold registers
`timescale 1ns/1ps
module fbst_tap
  import fbst_pkg::*;
#(
  parameter int BSR_W = 8
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // Device side
  input wire logic [BSR_W-1:0] pin_in,
  input wire logic [BSR_W-1:0] core_out,
  output logic [BSR_W-1:0] pin_out,
  output logic pins_hiz,
  output logic test_mode,
  output logic port_was_reset,
  input wire logic [THR_W-1:0] almost_empty_thr_in,
  input wire logic [THR_W-1:0] almost_full_thr_in,
  output logic [THR_W-1:0] almost_empty_thr,
  output logic [THR_W-1:0] almost_full_thr,
  output logic thr_load
);

  localparam int THR2 = 2 * THR_W;

  // Two-stage synchronisers for the port pins
  logic [1:0] tck_s, tms_s, tdi_s, trst_s;
  logic tck_d;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tck_s <= 2'h0;
      tms_s <= 2'h0;
      tdi_s <= 2'h0;
      trst_s <= 2'h0;
      tck_d <= 1'b0;
    end else begin
      tck_s <= {tck_s[0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      trst_s <= {trst_s[0], trst_n};
      tck_d <= tck_s[1];
    end
  end

  logic rise, fall, trst_act;
  assign rise = tck_s[1] & ~tck_d;
  assign fall = ~tck_s[1] & tck_d;
  assign trst_act = ~trst_s[1];

  // Device pin values pass two flip-flops before the boundary cells capture them
  logic [BSR_W-1:0] pin_s0_r, pin_s1_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s0_r <= '0;
      pin_s1_r <= '0;
    end else begin
      pin_s0_r <= pin_in;
      pin_s1_r <= pin_s0_r;
    end
  end

  // State machine
  fbst_state_t state_r, state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:  state_nxt = tms_s[1] ? ST_RESET : ST_IDLE;
      ST_IDLE:   state_nxt = tms_s[1] ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = tms_s[1] ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms_s[1] ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_nxt = tms_s[1] ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tms_s[1] ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_nxt = tms_s[1] ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_nxt = tms_s[1] ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tms_s[1] ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = tms_s[1] ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms_s[1] ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_nxt = tms_s[1] ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tms_s[1] ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_nxt = tms_s[1] ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_nxt = tms_s[1] ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tms_s[1] ? ST_SEL_DR : ST_IDLE;
      default:   state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_RESET;
    end else if (trst_act) begin
      state_r <= ST_RESET;
    end else if (rise) begin
      state_r <= state_nxt;
    end
  end

  // Port has seen a reset; gates queue operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_was_reset <= 1'b0;
    end else if (state_r == ST_RESET) begin
      port_was_reset <= 1'b1;
    end
  end

  // Instruction shifter and hold latch
  logic [IR_W-1:0] ir_sh_r, instr_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (rise && state_r == ST_CAP_IR) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (rise && state_r == ST_SH_IR) begin
      ir_sh_r <= {tdi_s[1], ir_sh_r[IR_W-1:1]};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_r <= IR_RESET;
    end else if (state_r == ST_RESET) begin
      instr_r <= IR_RESET;
    end else if (fall && state_r == ST_UPD_IR) begin
      instr_r <= ir_sh_r;
    end
  end

  // Instruction decode
  logic sel_bsr, sel_id, sel_thr, sel_byp;
  assign sel_bsr = (instr_r == INS_EXTEST) || (instr_r == INS_SAMPLE);
  assign sel_id = (instr_r == INS_IDCODE);
  assign sel_thr = (instr_r == INS_THR_READ) || (instr_r == INS_THR_LOAD);
  assign sel_byp = ~(sel_bsr | sel_id | sel_thr);

  // Instructions under which the boundary update cells drive the pins
  function automatic logic drives_pins(input logic [IR_W-1:0] ins);
    return (ins == INS_EXTEST) || (ins == INS_CLAMP);
  endfunction

  localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Data registers; only the selected one captures or shifts
  logic byp_r;
  logic [31:0] id_r;
  logic [BSR_W-1:0] bsr_r, bsr_upd_r;
  logic [THR2-1:0] thr_sh_r;
  logic cap, shf;
  assign cap = rise && state_r == ST_CAP_DR;
  assign shf = rise && state_r == ST_SH_DR;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      byp_r <= 1'b0;
    end else if (sel_byp && cap) begin
      byp_r <= 1'b0;
    end else if (sel_byp && shf) begin
      byp_r <= tdi_s[1];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      id_r <= ID_VALUE;
    end else if (sel_id && cap) begin
      id_r <= ID_VALUE;
    end else if (sel_id && shf) begin
      id_r <= {tdi_s[1], id_r[31:1]};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bsr_r <= '0;
    end else if (sel_bsr && cap) begin
      bsr_r <= (instr_r == INS_EXTEST) ? pin_s1_r : core_out;
    end else if (sel_bsr && shf) begin
      bsr_r <= {tdi_s[1], bsr_r[BSR_W-1:1]};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bsr_upd_r <= '0;
    end else if (sel_bsr && fall && state_r == ST_UPD_DR) begin
      bsr_upd_r <= bsr_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thr_sh_r <= '0;
    end else if (sel_thr && cap) begin
      thr_sh_r <= {almost_full_thr_in, almost_empty_thr_in};
    end else if (sel_thr && shf) begin
      thr_sh_r <= {tdi_s[1], thr_sh_r[THR2-1:1]};
    end
  end

  // Threshold load on Update-DR under the load instruction
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      almost_empty_thr <= THR_EMPTY_RST;
      almost_full_thr <= THR_FULL_RST;
      thr_load <= 1'b0;
    end else begin
      thr_load <= 1'b0;
      if (instr_r == INS_THR_LOAD && fall && state_r == ST_UPD_DR) begin
        almost_empty_thr <= thr_sh_r[THR_W-1:0];
        almost_full_thr <= thr_sh_r[THR2-1:THR_W];
        thr_load <= 1'b1;
      end
    end
  end

  // Pin control; inactive in reset and for non-driving instructions except INS_HIGHZ, which raises pins_hiz
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out <= '0;
      pins_hiz <= 1'b0;
      test_mode <= 1'b0;
    end else if (state_r == ST_RESET) begin
      pin_out <= core_out;
      pins_hiz <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      test_mode <= drives_pins(instr_r);
      pins_hiz <= (instr_r == INS_HIGHZ);
      pin_out <= drives_pins(instr_r) ? bsr_upd_r : core_out;
    end
  end

  // Serial output mux, updated on falling edge
  logic dr_bit;
  always_comb begin
    if (sel_id) begin
      dr_bit = id_r[0];
    end else if (sel_bsr) begin
      dr_bit = bsr_r[0];
    end else if (sel_thr) begin
      dr_bit = thr_sh_r[0];
    end else begin
      dr_bit = byp_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo <= (state_r == ST_SH_IR) ? ir_sh_r[0] : dr_bit;
      tdo_oe <= (state_r == ST_SH_IR) || (state_r == ST_SH_DR);
    end
  end

  // Assertions
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tms_hi_cnt <= 3'h0;
    end else if (rise) begin
      tms_hi_cnt <= !tms_s[1] ? 3'h0 : (tms_hi_cnt == 3'h5 ? 3'h5 : tms_hi_cnt + 3'h1);
    end
  end

  a_tms_reset_five: assert property (@(posedge clk) disable iff (reset)
    tms_hi_cnt == 3'h5 |-> state_r == ST_RESET)
    else $error("five tms-high edges did not reach reset");

  a_state_only_rise: assert property (@(posedge clk) disable iff (reset)
    (!$past(rise) && !$past(trst_act)) |-> $stable(state_r))
    else $error("state changed without rising test clock");

  a_capir_pattern: assert property (@(posedge clk) disable iff (reset)
    (rise && state_r == ST_CAP_IR) |=> ir_sh_r[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");

  sequence s_paused_ir;
    state_r == ST_PAU_IR ##1 state_r == ST_PAU_IR;
  endsequence

  a_pause_holds: assert property (@(posedge clk) disable iff (reset)
    s_paused_ir |-> $stable(ir_sh_r))
    else $error("pause-ir lost shifter contents");

  a_reset_idcode: assert property (@(posedge clk) disable iff (reset)
    state_r == ST_RESET |=> instr_r == INS_IDCODE)
    else $error("identification not selected after port reset");

  a_bypass_clear: assert property (@(posedge clk) disable iff (reset)
    (sel_byp && cap) |=> !byp_r)
    else $error("bypass not cleared in capture-dr");

  a_id_constant: assert property (@(posedge clk) disable iff (reset)
    (sel_id && cap) |=> id_r == ID_VALUE && id_r[0])
    else $error("identification capture wrong");

  a_tdo_enable: assert property (@(posedge clk) disable iff (reset)
    (fall && state_r != ST_SH_IR && state_r != ST_SH_DR) |=> !tdo_oe)
    else $error("data out driven outside shift states");

  sequence s_held_in_reset;
    state_r == ST_RESET ##1 state_r == ST_RESET;
  endsequence

  a_reset_inactive: assert property (@(posedge clk) disable iff (reset)
    s_held_in_reset |-> !test_mode && !pins_hiz)
    else $error("test logic active in reset state");

  a_instr_update: assert property (@(posedge clk) disable iff (reset)
    (fall && state_r == ST_UPD_IR) |=> instr_r == $past(ir_sh_r))
    else $error("instruction not taken at update-ir falling edge");

  a_thr_load_only: assert property (@(posedge clk) disable iff (reset)
    thr_load |-> $past(instr_r) == INS_THR_LOAD && $past(state_r) == ST_UPD_DR)
    else $error("threshold load outside the load instruction");

  a_unsel_bsr_stable: assert property (@(posedge clk) disable iff (reset)
    !sel_bsr |=> $stable(bsr_r))
    else $error("unselected boundary register disturbed");

  a_bypass_shift: assert property (@(posedge clk) disable iff (reset)
    (sel_byp && shf) |=> byp_r == $past(tdi_s[1]))
    else $error("bypass stage did not take serial input");

endmodule // fbst_tap

// File: testbench/fbst_host.sv
// Behavioural boundary-scan controller that drives the test port pins
`timescale 1ns/1ps
module fbst_host (
  // Test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  int oe_miss = 0;
  // No parallel threshold signals here: thresholds are loaded serially through tdi, and the bench drives the threshold inputs

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // One test clock of 125 ns; returns {tdo_oe, tdo} seen at the rising edge
  task automatic step(input logic m, input logic d, output logic [1:0] q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = {tdo_oe, tdo};
    #62.5 tck = 1'b0;
  endtask

  // Five clocks with mode select high, then park in Run-Test-Idle
  task automatic tlr();
    logic [1:0] q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // Pulse the test reset, then park in Run-Test-Idle where scans start
  task automatic treset();
    logic [1:0] q;
    trst_n = 1'b0;
    #100 trst_n = 1'b1;
    #100;
    step(1'b0, 1'b0, q);
  endtask

  // Scan from idle back to idle, LSB first, optionally pausing after bit pause_at
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input int pause_at, output logic [31:0] dout);
    logic [1:0] q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pause_at, din[i], q);
      dout[i] = q[0];
      if (q[1] !== 1'b1)
        oe_miss++;
      if (i == pause_at && i != n - 1) begin
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        if (q[1] !== 1'b0)
          oe_miss++;
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
      end
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // fbst_host

// File: testbench/test_fbst_tap.sv
// Self-checking bench for the FIFO boundary-scan test port
`timescale 1ns/1ps
module test_fbst_tap;
  import fbst_pkg::*;
  localparam int BSR_W = 8;
  localparam int LIMIT = 40000;
  logic clk, reset, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [BSR_W-1:0] pin_in, core_out, pin_out, bsr_upd;
  logic pins_hiz, test_mode, port_was_reset, thr_load;
  logic [THR_W-1:0] ae_in, af_in, ae_thr, af_thr;
  logic [31:0] d, din, exp, thr_exp, id_exp, r;
  logic [3:0] codes [9] = '{INS_EXTEST, INS_SAMPLE, INS_IDCODE, INS_CLAMP, INS_HIGHZ,
                            INS_THR_READ, INS_THR_LOAD, INS_BYPASS, 4'h5};
  logic [3:0] c;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int loads = 0;
  int n;
  integer seed;

  fbst_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
                  .tdo_oe(tdo_oe));
  fbst_tap #(.BSR_W(BSR_W)) dut (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
    .core_out(core_out), .pin_out(pin_out), .pins_hiz(pins_hiz), .test_mode(test_mode),
    .port_was_reset(port_was_reset), .almost_empty_thr_in(ae_in),
    .almost_full_thr_in(af_in), .almost_empty_thr(ae_thr), .almost_full_thr(af_thr),
    .thr_load(thr_load));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    num_checks++;
    if (got !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  // Threshold load pulses seen by the bench
  always @(negedge clk) begin
    if (thr_load === 1'b1)
      loads++;
  end

  initial begin
    seed = 32'h44412dcb;
    id_exp = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    thr_exp = {THR_FULL_RST, THR_EMPTY_RST};
    bsr_upd = '0;
    reset = 1'b1;
    pin_in = '0;
    core_out = '0;
    ae_in = '0;
    af_in = '0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    // Wander through the state graph, then five mode-high clocks
    repeat (7) begin
      r = $random(seed);
      host.step(r[0], r[1], d[1:0]);
    end
    host.tlr();
    chk("port reset", 32'h1, {31'h0, port_was_reset});
    host.scan(1'b0, 32, $random(seed), -1, d);
    chk("idcode after reset", id_exp, d);
    foreach (codes[k]) begin
      c = codes[k];
      @(negedge clk);
      r = $random(seed);
      core_out = r[BSR_W-1:0];
      pin_in = r[2*BSR_W-1:BSR_W];
      r = $random(seed);
      {af_in, ae_in} = r;
      din = $random(seed);
      loads = 0;
      host.scan(1'b1, IR_W, {28'h0, c}, 1, d);
      chk("ir capture", {28'h0, IR_CAPTURE}, d);
      n = (c == INS_EXTEST || c == INS_SAMPLE) ? BSR_W :
          (c == INS_IDCODE || c == INS_THR_READ || c == INS_THR_LOAD) ? 32 : 8;
      host.scan(1'b0, n, din, n / 2, d);
      case (c)
        INS_EXTEST: exp = {24'h0, pin_in};
        INS_SAMPLE: exp = {24'h0, core_out};
        INS_IDCODE: exp = id_exp;
        INS_THR_READ, INS_THR_LOAD: exp = {af_in, ae_in};
        default: exp = {24'h0, din[6:0], 1'b0};
      endcase
      chk("data scan out", exp, d);
      if (c == INS_EXTEST || c == INS_SAMPLE)
        bsr_upd = din[7:0];
      if (c == INS_THR_LOAD)
        thr_exp = din;
      repeat (6) @(negedge clk);
      chk("thresholds", thr_exp, {af_thr, ae_thr});
      chk("threshold load pulses", {31'h0, c == INS_THR_LOAD}, loads);
      chk("test mode", {31'h0, c == INS_EXTEST || c == INS_CLAMP}, {31'h0, test_mode});
      chk("high impedance", {31'h0, c == INS_HIGHZ}, {31'h0, pins_hiz});
      exp = (c == INS_EXTEST || c == INS_CLAMP) ? {24'h0, bsr_upd} : {24'h0, core_out};
      chk("pin out", exp, {24'h0, pin_out});
    end
    host.treset();
    host.scan(1'b0, 32, $random(seed), -1, d);
    chk("idcode after trst", id_exp, d);
    repeat (6) @(negedge clk);
    chk("pin out after trst", {24'h0, core_out}, {24'h0, pin_out});
    chk("tdo enable idle", 32'h0, {31'h0, tdo_oe});
    chk("tdo enable misses", 32'h0, host.oe_miss);
    print_verdict();
  end
endmodule // test_fbst_tap
